// File: hw/rtcco_pkg.sv
package rtcco_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_DATE = 8'h06;
  localparam logic [7:0] IDX_MONTH = 8'h07;
  localparam logic [7:0] IDX_YEAR = 8'h08;
  localparam logic [7:0] IDX_PULSE_CFG = 8'h0f;
  localparam logic [7:0] IDX_STATUS = 8'h10;
  localparam logic [7:0] ADDR_DATE = 8'(IDX_DATE * 4);
  localparam logic [7:0] ADDR_MONTH = 8'(IDX_MONTH * 4);
  localparam logic [7:0] ADDR_YEAR = 8'(IDX_YEAR * 4);
  localparam logic [7:0] ADDR_PULSE_CFG = 8'(IDX_PULSE_CFG * 4);
  localparam logic [7:0] ADDR_STATUS = 8'(IDX_STATUS * 4);

  typedef enum logic [2:0] {
    RTCCO_REG_NONE,
    RTCCO_REG_CFG,
    RTCCO_REG_DATE,
    RTCCO_REG_MONTH,
    RTCCO_REG_YEAR,
    RTCCO_REG_STATUS
  } rtcco_reg_e;

  // ----------------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------------
  localparam int CFG_SLEEP_OVR = 7;
  localparam int CFG_ENABLE = 6;
  localparam int CFG_RATE_HI = 5;
  localparam int CFG_RATE_LO = 4;
  localparam int CFG_ROUTE_HI = 3;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int NUM_PINS = 4;
  localparam int PIN_P0B5 = 0;
  localparam logic [1:0] RATE_1HZ = 2'h0;
  localparam logic [1:0] RATE_512HZ = 2'h1;
  localparam logic [1:0] RATE_500HZ = 2'h2;
  localparam logic [1:0] RATE_16KHZ = 2'h3;
  localparam int STS_SLEEP = 0;
  localparam int STS_PULSE = 1;
  localparam int STS_FAST = 2;

  // ----------------------------------------------------------------------
  // Calendar
  // ----------------------------------------------------------------------
  localparam logic [7:0] DATE_RESET = 8'h01;
  localparam logic [7:0] MONTH_RESET = 8'h01;
  localparam logic [7:0] YEAR_RESET = 8'h00;
  localparam logic [7:0] DAY_FIRST = 8'h01;
  localparam logic [7:0] MONTH_FIRST = 8'h01;
  localparam logic [7:0] MONTH_LAST = 8'h0c;
  localparam logic [7:0] MON_FEB = 8'h02;
  localparam logic [7:0] MON_APR = 8'h04;
  localparam logic [7:0] MON_JUN = 8'h06;
  localparam logic [7:0] MON_SEP = 8'h09;
  localparam logic [7:0] MON_NOV = 8'h0b;
  localparam logic [7:0] DAYS_LONG = 8'h1f;
  localparam logic [7:0] DAYS_SHORT = 8'h1e;
  localparam logic [7:0] DAYS_FEB_LEAP = 8'h1d;
  localparam logic [7:0] DAYS_FEB = 8'h1c;
  localparam logic [7:0] LEAP_FIRST = 8'h04;
  localparam logic [7:0] LEAP_LAST = 8'h60;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned FREQ_1HZ = 1;
  localparam int unsigned FREQ_512HZ = 512;
  localparam int unsigned FREQ_500HZ = 500;
  localparam int unsigned FREQ_16KHZ = 16_000;
  localparam int unsigned TICK_HZ = 128;
  localparam int unsigned FAST_FACTOR = 125;
  localparam int unsigned HALF_1HZ = CLK_HZ / (2 * FREQ_1HZ);
  localparam int unsigned HALF_512HZ = CLK_HZ / (2 * FREQ_512HZ);
  localparam int unsigned HALF_500HZ = CLK_HZ / (2 * FREQ_500HZ);
  localparam int unsigned HALF_16KHZ = CLK_HZ / (2 * FREQ_16KHZ);
  localparam int unsigned TICK_NORMAL = CLK_HZ / TICK_HZ;
  localparam int unsigned TICK_FAST = CLK_HZ / (TICK_HZ * FAST_FACTOR);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: hw/rtcco_calendar.sv
`timescale 1ns/10ps
module rtcco_calendar (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic dayCarry,
  input wire logic wrDate,
  input wire logic wrMonth,
  input wire logic wrYear,
  input wire logic [7:0] wrData,
  output logic [7:0] date,
  output logic [7:0] month,
  output logic [7:0] year
);

  // ----------------------------------------------------------------------
  // Month length
  // ----------------------------------------------------------------------
  function automatic logic [7:0] lastDay(input logic [7:0] mon,
                                         input logic [7:0] yr);
    logic leap;
    leap = (yr[1:0] == 2'h0) && (yr >= rtcco_pkg::LEAP_FIRST) &&
           (yr <= rtcco_pkg::LEAP_LAST);
    if (mon == rtcco_pkg::MON_FEB) begin
      lastDay = leap ? rtcco_pkg::DAYS_FEB_LEAP : rtcco_pkg::DAYS_FEB;
    end else if (mon == rtcco_pkg::MON_APR || mon == rtcco_pkg::MON_JUN ||
                 mon == rtcco_pkg::MON_SEP || mon == rtcco_pkg::MON_NOV) begin
      lastDay = rtcco_pkg::DAYS_SHORT;
    end else begin
      lastDay = rtcco_pkg::DAYS_LONG;
    end
  endfunction

  logic dayWrap;
  logic monthWrap;

  assign dayWrap = dayCarry && (date >= lastDay(month, year));
  assign monthWrap = dayWrap && (month >= rtcco_pkg::MONTH_LAST);

  // ----------------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------------
  // A software write in the same cycle as a carry wins in the written register,
  // but the wrap still uses the old date, so unwritten fields can still advance.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      date <= rtcco_pkg::DATE_RESET;
    end else if (wrDate) begin
      date <= wrData;
    end else if (dayWrap) begin
      date <= rtcco_pkg::DAY_FIRST;
    end else if (dayCarry) begin
      date <= date + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      month <= rtcco_pkg::MONTH_RESET;
    end else if (wrMonth) begin
      month <= wrData;
    end else if (monthWrap) begin
      month <= rtcco_pkg::MONTH_FIRST;
    end else if (dayWrap) begin
      month <= month + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      year <= rtcco_pkg::YEAR_RESET;
    end else if (wrYear) begin
      year <= wrData;
    end else if (monthWrap) begin
      year <= year + 8'h01;
    end
  end

endmodule // rtcco_calendar

// File: hw/rtcco_top.sv
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module rtcco_top #(
  parameter int unsigned HALF_1HZ = rtcco_pkg::HALF_1HZ,
  parameter int unsigned HALF_512HZ = rtcco_pkg::HALF_512HZ,
  parameter int unsigned HALF_500HZ = rtcco_pkg::HALF_500HZ,
  parameter int unsigned TICK_NORMAL = rtcco_pkg::TICK_NORMAL,
  parameter int unsigned TICK_FAST = rtcco_pkg::TICK_FAST
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic deepSleepMode,
  input wire logic dayCarry,
  input wire logic [3:0] portFuncOut,
  input wire logic [3:0] portFuncOe,
  output logic [3:0] pinOut,
  output logic [3:0] pinOe,
  output logic timeTick,
  output logic fastTimebase
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic rtcco_pkg::rtcco_reg_e decodeReg(input logic [7:0] a);
    unique case (a)
      rtcco_pkg::ADDR_PULSE_CFG: decodeReg = rtcco_pkg::RTCCO_REG_CFG;
      rtcco_pkg::ADDR_DATE: decodeReg = rtcco_pkg::RTCCO_REG_DATE;
      rtcco_pkg::ADDR_MONTH: decodeReg = rtcco_pkg::RTCCO_REG_MONTH;
      rtcco_pkg::ADDR_YEAR: decodeReg = rtcco_pkg::RTCCO_REG_YEAR;
      rtcco_pkg::ADDR_STATUS: decodeReg = rtcco_pkg::RTCCO_REG_STATUS;
      default: decodeReg = rtcco_pkg::RTCCO_REG_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------------
  logic awHeld;
  logic [7:0] awAddr;
  logic wHeld;
  logic [7:0] wData;
  logic wLane0;
  logic doWrite;
  rtcco_pkg::rtcco_reg_e wrReg;

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign wrReg = decodeReg(awAddr);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      awHeld <= 1'b0;
      awAddr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wHeld <= 1'b0;
      wData <= 8'h00;
      wLane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata[7:0];
      wLane0 <= s_axi_wstrb[0];
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rtcco_pkg::RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      if (wrReg == rtcco_pkg::RTCCO_REG_NONE) begin
        s_axi_bresp <= rtcco_pkg::RESP_SLVERR;
      end else begin
        s_axi_bresp <= rtcco_pkg::RESP_OKAY;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Pulse configuration
  // ----------------------------------------------------------------------
  // Only byte lane 0 carries the register; other lanes are dropped.
  logic [7:0] pulseCfg;
  logic cfgWrite;
  logic sleepPulseOverride;
  logic pulseEnable;
  logic [1:0] pulseRateSelect;
  logic [3:0] route;

  assign cfgWrite = doWrite && wLane0 && (wrReg == rtcco_pkg::RTCCO_REG_CFG);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pulseCfg <= rtcco_pkg::CFG_RESET;
    end else if (cfgWrite) begin
      pulseCfg <= wData;
    end
  end

  assign sleepPulseOverride = pulseCfg[rtcco_pkg::CFG_SLEEP_OVR];
  assign pulseEnable = pulseCfg[rtcco_pkg::CFG_ENABLE];
  assign pulseRateSelect = pulseCfg[rtcco_pkg::CFG_RATE_HI:
                                    rtcco_pkg::CFG_RATE_LO];
  assign route = pulseCfg[rtcco_pkg::CFG_ROUTE_HI:0];

  // ----------------------------------------------------------------------
  // Calendar
  // ----------------------------------------------------------------------
  logic [7:0] date;
  logic [7:0] month;
  logic [7:0] year;
  logic calWrite;

  assign calWrite = doWrite && wLane0;

  rtcco_calendar u_calendar (
    .ref_clk(ref_clk),
    .reset(reset),
    .dayCarry(dayCarry),
    .wrDate(calWrite && (wrReg == rtcco_pkg::RTCCO_REG_DATE)),
    .wrMonth(calWrite && (wrReg == rtcco_pkg::RTCCO_REG_MONTH)),
    .wrYear(calWrite && (wrReg == rtcco_pkg::RTCCO_REG_YEAR)),
    .wrData(wData),
    .date(date),
    .month(month),
    .year(year)
  );

  // ----------------------------------------------------------------------
  // Pulse generator
  // ----------------------------------------------------------------------
  logic [31:0] halfPeriod;
  logic [31:0] pulseCount;
  logic pulseLevel;

  always_comb begin
    unique case (pulseRateSelect)
      rtcco_pkg::RATE_1HZ: halfPeriod = 32'(HALF_1HZ);
      rtcco_pkg::RATE_512HZ: halfPeriod = 32'(HALF_512HZ);
      rtcco_pkg::RATE_500HZ: halfPeriod = 32'(HALF_500HZ);
      rtcco_pkg::RATE_16KHZ: halfPeriod = 32'(rtcco_pkg::HALF_16KHZ);
    endcase
  end

  // A configuration write restarts the period at a low level, so a write made
  // while the pulse is low stretches that low half by a new half period.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pulseCount <= 32'h0;
      pulseLevel <= 1'b0;
    end else if (!pulseEnable || cfgWrite) begin
      pulseCount <= 32'h0;
      pulseLevel <= 1'b0;
    end else if (pulseCount >= halfPeriod - 32'h1) begin
      pulseCount <= 32'h0;
      pulseLevel <= !pulseLevel;
    end else begin
      pulseCount <= pulseCount + 32'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Timekeeping tick
  // ----------------------------------------------------------------------
  logic [31:0] tickPeriod;
  logic [31:0] tickCount;

  assign fastTimebase = pulseRateSelect[1];
  assign tickPeriod = fastTimebase ? 32'(TICK_FAST) : 32'(TICK_NORMAL);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tickCount <= 32'h0;
      timeTick <= 1'b0;
    end else if (tickCount >= tickPeriod - 32'h1) begin
      tickCount <= 32'h0;
      timeTick <= 1'b1;
    end else begin
      tickCount <= tickCount + 32'h1;
      timeTick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Pin routing
  // ----------------------------------------------------------------------
  // The pin output flop adds one cycle from a mode change to the pin, which
  // is far below any pulse period.
  logic [3:0] routed;

  genvar gi;
  generate
    for (gi = 0; gi < rtcco_pkg::NUM_PINS; gi++) begin : g_pin
      if (gi == rtcco_pkg::PIN_P0B5) begin : g_main
        assign routed[gi] = pulseEnable && (deepSleepMode ?
                            sleepPulseOverride : route[gi]);
      end else begin : g_other
        assign routed[gi] = pulseEnable && route[gi] && !deepSleepMode;
      end
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          pinOut[gi] <= 1'b0;
          pinOe[gi] <= 1'b0;
        end else if (routed[gi]) begin
          pinOut[gi] <= pulseLevel;
          pinOe[gi] <= 1'b1;
        end else begin
          pinOut[gi] <= portFuncOut[gi];
          pinOe[gi] <= portFuncOe[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------
  logic [7:0] status;
  logic [7:0] readByte;
  rtcco_pkg::rtcco_reg_e rdReg;

  always_comb begin
    status = 8'h00;
    status[rtcco_pkg::STS_SLEEP] = deepSleepMode;
    status[rtcco_pkg::STS_PULSE] = pulseLevel;
    status[rtcco_pkg::STS_FAST] = fastTimebase;
  end

  assign rdReg = decodeReg(s_axi_araddr);

  always_comb begin
    unique case (rdReg)
      rtcco_pkg::RTCCO_REG_CFG: readByte = pulseCfg;
      rtcco_pkg::RTCCO_REG_DATE: readByte = date;
      rtcco_pkg::RTCCO_REG_MONTH: readByte = month;
      rtcco_pkg::RTCCO_REG_YEAR: readByte = year;
      rtcco_pkg::RTCCO_REG_STATUS: readByte = status;
      default: readByte = 8'h00;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= rtcco_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h0, readByte};
      if (rdReg == rtcco_pkg::RTCCO_REG_NONE) begin
        s_axi_rresp <= rtcco_pkg::RESP_SLVERR;
      end else begin
        s_axi_rresp <= rtcco_pkg::RESP_OKAY;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // rtcco_top

// File: verif/rtcco_monitor.sv
`timescale 1ns/10ps
module rtcco_monitor (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic deepSleepMode,
  input wire logic [3:0] portFuncOut,
  input wire logic [3:0] portFuncOe,
  input wire logic [3:0] pinOut,
  input wire logic [3:0] pinOe,
  input wire logic timeTick,
  input wire logic fastTimebase
);
  // --------------------------------------------------------------------
  // Shadow of the configuration, one cycle behind the real register
  // --------------------------------------------------------------------
  // The lag matches the registered pins, so no $past is needed on it.
  logic [7:0] cfgSh;
  logic [7:0] wrAddr;
  logic [8:0] wrData;
  logic bvPrev;
  logic pastRst;
  logic pastDeep;
  logic [3:0] pastOe;
  logic [3:0] pastOut;
  logic [3:0] rt;
  always_ff @(posedge ref_clk) begin
    if (s_axi_awvalid && s_axi_awready) wrAddr <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready)
      wrData <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
    pastDeep <= deepSleepMode;
    pastOe <= portFuncOe;
    pastOut <= portFuncOut;
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cfgSh <= 8'h00;
      bvPrev <= 1'b0;
      pastRst <= 1'b1;
    end else begin
      bvPrev <= s_axi_bvalid;
      pastRst <= 1'b0;
      if (s_axi_bvalid && !bvPrev && wrData[8] &&
          wrAddr == rtcco_pkg::ADDR_PULSE_CFG) cfgSh <= wrData[7:0];
    end
  end
  always_comb begin
    rt = cfgSh[6] ? cfgSh[3:0] : 4'h0;
    if (pastDeep) rt = {3'h0, cfgSh[6] & cfgSh[7]};
  end
  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  route_oe_a: assert property (!pastRst |->
    pinOe == (rt | pastOe))
    else $error("pin enables differ from routing");
  unrouted_out_a: assert property (!pastRst |->
    ((pinOut ^ pastOut) & ~rt) == 4'h0)
    else $error("unrouted pin lost its own drive");
  sleep_pin0_a: assert property (!pastRst && pastDeep &&
    cfgSh[7:6] == 2'h3 |-> pinOe[0])
    else $error("sleep override did not drive pin 0");
  sleep_block_a: assert property (!pastRst && pastDeep |->
    ((pinOe ^ pastOe) & 4'he) == 4'h0)
    else $error("pulse reached a pin in deep sleep");
  pin0_route_a: assert property (!pastRst && !pastDeep &&
    cfgSh[6] && cfgSh[0] |-> pinOe[0])
    else $error("pin 0 not routed");
  fast_base_a: assert property (1'b1 |=>
    cfgSh[5] == $past(fastTimebase))
    else $error("fast timebase differs from rate select");
  tick_gap_a: assert property (timeTick |=> !timeTick [*3])
    else $error("timekeeping ticks too close");
  wr_answer_a: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late");
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
endmodule // rtcco_monitor

bind rtcco_top rtcco_monitor u_mon (.ref_clk, .reset, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .deepSleepMode, .portFuncOut, .portFuncOe, .pinOut, .pinOe, .timeTick,
  .fastTimebase);

// File: verif/rtcco_freq_counter.sv
`timescale 1ns/10ps
module rtcco_freq_counter (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic pin,
  output logic [31:0] halfPeriod
);
  // --------------------------------------------------------------------
  // Half period meter
  // --------------------------------------------------------------------
  // Reports the cycles between the last two edges, so one stale half
  // period after a rate change is harmless if enough edges are awaited.
  logic [31:0] count;
  logic last;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      count <= 32'h0;
      last <= 1'b0;
      halfPeriod <= 32'h0;
    end else begin
      last <= pin;
      count <= (pin != last) ? 32'h1 : count + 32'h1;
      if (pin != last) halfPeriod <= count;
    end
  end
endmodule // rtcco_freq_counter

// File: verif/rtc_cal_output_and_calendar_tb.sv
`timescale 1ns/10ps
module rtc_cal_output_and_calendar_tb;
  // --------------------------------------------------------------------
  // Stimulus and design
  // --------------------------------------------------------------------
  localparam int H1 = 8;
  localparam int H512 = 6;
  localparam int H500 = 5;
  localparam int TN = 500;
  localparam int TF = TN / rtcco_pkg::FAST_FACTOR;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic deepSleepMode = 1'b0;
  logic dayCarry = 1'b0;
  logic [3:0] portFuncOut = 4'h3;
  logic [3:0] portFuncOe = 4'h0;
  logic [3:0] pinOut;
  logic [3:0] pinOe;
  logic timeTick;
  logic fastTimebase;
  logic [31:0] halfPeriod;
  int miscompares = 0;
  int nTests = 0;
  int cycles = 0;
  int tickAge = 0;
  int tickGap = 0;
  always #5 ref_clk = ~ref_clk;
  rtcco_top #(.HALF_1HZ(H1), .HALF_512HZ(H512), .HALF_500HZ(H500),
    .TICK_NORMAL(TN), .TICK_FAST(4)) u_dut (.ref_clk, .reset, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .deepSleepMode, .dayCarry, .portFuncOut, .portFuncOe,
    .pinOut, .pinOe, .timeTick, .fastTimebase);
  rtcco_freq_counter u_meter (.ref_clk, .reset, .pin(pinOut[0]), .halfPeriod);
  // --------------------------------------------------------------------
  // Bus and checking tasks
  // --------------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check("bresp", {30'h0, r}, {30'h0, rtcco_pkg::RESP_OKAY});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check("rdata", d, exp);
    check("rresp", {30'h0, r}, {30'h0, rtcco_pkg::RESP_OKAY});
  endtask
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic reg_test();
    logic [31:0] d;
    logic [1:0] r;
    rd(rtcco_pkg::ADDR_PULSE_CFG, 32'h0);
    rd(rtcco_pkg::ADDR_DATE, 32'h1);
    rd(rtcco_pkg::ADDR_MONTH, 32'h1);
    rd(rtcco_pkg::ADDR_YEAR, 32'h0);
    axi_write(8'h44, 32'h1, r);
    check("bresp", {30'h0, r}, {30'h0, rtcco_pkg::RESP_SLVERR});
    axi_read(8'h44, d, r);
    check("rresp", {30'h0, r}, {30'h0, rtcco_pkg::RESP_SLVERR});
    check("rdata", d, 32'h0);
    rd(rtcco_pkg::ADDR_STATUS, 32'h0);
    wr(rtcco_pkg::ADDR_STATUS, 32'hff);
    s_axi_wstrb <= 4'he;
    wr(rtcco_pkg::ADDR_PULSE_CFG, 32'hff);
    s_axi_wstrb <= 4'h1;
    rd(rtcco_pkg::ADDR_PULSE_CFG, 32'h0);
    $display("register test done");
  endtask
  task automatic route_case(input logic deep, input logic [7:0] cfg,
    input logic [3:0] fOe, input logic [3:0] exp);
    deepSleepMode <= deep;
    portFuncOe <= fOe;
    wr(rtcco_pkg::ADDR_PULSE_CFG, {24'h0, cfg});
    repeat (2) @(posedge ref_clk);
    check("pinOe", {28'h0, pinOe}, {28'h0, exp});
    check("pinOut", {28'h0, pinOut & ~exp},
      {28'h0, portFuncOut & ~exp});
  endtask
  task automatic route_test();
    route_case(1'b0, 8'h41, 4'h0, 4'h1);
    route_case(1'b0, 8'h42, 4'h0, 4'h2);
    route_case(1'b0, 8'h44, 4'h0, 4'h4);
    route_case(1'b0, 8'h48, 4'h0, 4'h8);
    route_case(1'b0, 8'h0f, 4'ha, 4'ha);
    route_case(1'b0, 8'h80, 4'h0, 4'h0);
    route_case(1'b1, 8'hcf, 4'h0, 4'h1);
    route_case(1'b1, 8'h4f, 4'h0, 4'h0);
    route_case(1'b1, 8'hc0, 4'h4, 4'h5);
    $display("routing test done");
  endtask
  task automatic rate_test();
    int half [4] = '{H1, H512, H500, rtcco_pkg::HALF_16KHZ};
    deepSleepMode <= 1'b0;
    for (int r = 0; r < 4; r++) begin
      wr(rtcco_pkg::ADDR_PULSE_CFG, 32'h41 | (r << 4));
      repeat (3 * half[r] + 4) @(posedge ref_clk);
      check("halfPeriod", halfPeriod, half[r]);
      check("fastTimebase", {31'h0, fastTimebase}, {31'h0, r[1]});
      repeat (2 * TN) @(posedge ref_clk);
      check("tickGap", tickGap, r[1] ? TF : TN);
    end
    $display("rate test done");
  endtask
  task automatic carry();
    dayCarry <= 1'b1;
    @(posedge ref_clk);
    dayCarry <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic cal_case(input logic [7:0] m, input logic [7:0] y,
    input logic [7:0] last, input logic [7:0] nm, input logic [7:0] ny);
    wr(rtcco_pkg::ADDR_MONTH, {24'h0, m});
    wr(rtcco_pkg::ADDR_YEAR, {24'h0, y});
    wr(rtcco_pkg::ADDR_DATE, {24'h0, last - 8'h01});
    carry();
    rd(rtcco_pkg::ADDR_DATE, {24'h0, last});
    carry();
    rd(rtcco_pkg::ADDR_DATE, 32'h1);
    rd(rtcco_pkg::ADDR_MONTH, {24'h0, nm});
    rd(rtcco_pkg::ADDR_YEAR, {24'h0, ny});
  endtask
  task automatic cal_test();
    cal_case(8'h01, 8'h00, 8'h1f, 8'h02, 8'h00);
    cal_case(8'h04, 8'h00, 8'h1e, 8'h05, 8'h00);
    cal_case(8'h0b, 8'h00, 8'h1e, 8'h0c, 8'h00);
    cal_case(8'h02, 8'h04, 8'h1d, 8'h03, 8'h04);
    cal_case(8'h02, 8'h05, 8'h1c, 8'h03, 8'h05);
    cal_case(8'h02, 8'h00, 8'h1c, 8'h03, 8'h00);
    cal_case(8'h02, 8'h60, 8'h1d, 8'h03, 8'h60);
    cal_case(8'h02, 8'h64, 8'h1c, 8'h03, 8'h64);
    cal_case(8'h0c, 8'h07, 8'h1f, 8'h01, 8'h08);
    $display("calendar test done");
  endtask
  // --------------------------------------------------------------------
  // Run control
  // --------------------------------------------------------------------
  always @(posedge ref_clk) begin
    cycles++;
    tickAge <= (timeTick === 1'b1) ? 0 : tickAge + 1;
    if (timeTick === 1'b1) begin
      tickGap <= tickAge + 1;
    end
    if (cycles == 40000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    reg_test();
    route_test();
    rate_test();
    cal_test();
    final_report();
  end
endmodule // rtc_cal_output_and_calendar_tb
